// [lsap_ms_tick.sv]
// module: millisecond enable pulse divider
`timescale 1ns/1ps
module lsap_ms_tick #(
    parameter int unsigned CYCLES = 25000
) (
    input  wire logic clk,
    input  wire logic rst,
    output logic      tick
);
    localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    if (CYCLES < 1)
    begin : g_check
        $error("lsap_ms_tick needs at least one cycle per tick");
    end

    logic [CW-1:0] count;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count <= '0;
            tick  <= 1'b0;
        end
        else
        begin
            tick  <= (count == LAST);
            count <= (count == LAST) ? '0 : count + 1'b1;
        end
    end
endmodule

// [lsap_pkg.sv]
// package: constants, register map and carriers of the load input state block
package lsap_pkg;

    // ======================================================
    // timing
    localparam int CLK_PERIOD_NS  = 40;
    localparam int MS_NS          = 1000000;
    localparam int CYCLES_PER_MS  = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BACKLIGHT_S    = 60;
    localparam int BACKLIGHT_MS   = BACKLIGHT_S * 1000;
    localparam logic [15:0] LOG_INTERVAL_MS [4] = '{16'h01F4, 16'h03E8, 16'h07D0, 16'h1388};

    // ======================================================
    // register map (byte addresses)
    localparam logic [7:0] ADDR_CONFIG    = 8'h00;
    localparam logic [7:0] ADDR_CONTROL   = 8'h04;
    localparam logic [7:0] ADDR_STATUS    = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h10;
    localparam logic [7:0] ADDR_ALARM_CNT = 8'h14;

    // control bits, write-only pulses
    localparam int CTRL_DC_ON    = 0;
    localparam int CTRL_DC_OFF   = 1;
    localparam int CTRL_LOG_TGL  = 2;
    localparam int CTRL_FACTORY  = 3;
    localparam int CTRL_ACTIVITY = 4;

    // interrupt bits
    localparam int IRQ_W   = 7;
    localparam int IRQ_TH  = 0;
    localparam int IRQ_PL  = 1;
    localparam int IRQ_OVV = 2;
    localparam int IRQ_OVI = 3;
    localparam int IRQ_OVW = 4;
    localparam int IRQ_DC  = 5;
    localparam int IRQ_LOG = 6;

    localparam int CFG_W = 17;
    localparam int CNT_W = 16;

    // ======================================================
    // carriers
    typedef struct packed {
        logic       log_dc_coupled;
        logic [1:0] log_interval;
        logic       backlight_timeout;
        logic       th_stay_off;
        logic       remote_keep;
        logic       pl_auto;
        logic       power_on_restore;
        logic       pin15_dc_status;
        logic [2:0] pin14_select;
        logic [1:0] pin6_select;
        logic       standby_on_off;
        logic       standby_inverted;
        logic       range_10v;
    } lsap_config_t;

    typedef struct packed {
        logic ovw;
        logic ovi;
        logic ovv;
        logic pl;
        logic th;
    } lsap_alarm_t;

    localparam lsap_config_t CFG_RESET = 17'h00038;

endpackage

// [lsap_props.sv]
// checker: port-level properties of the load input state block
`timescale 1ns/1ps
module lsap_props (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic IRQ,
    input wire logic OVERTEMPERATURE_ALARM,
    input wire logic POWER_FAIL_ALARM,
    input wire logic POWER_SWITCH_OFF,
    input wire logic USER_ACTIVITY,
    input wire logic DC_INPUT_ENABLE,
    input wire logic BACKLIGHT_ON,
    input wire logic LOG_ACTIVE,
    input wire logic LOG_NEW_FILE,
    input wire logic LOG_RECORD,
    input wire logic NV_STORE
);
    // ======================================================
    // properties
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    pl_forces_off_a: assert property (POWER_FAIL_ALARM |=> !DC_INPUT_ENABLE)
        else $error("dc input on during power fail");
    th_forces_off_a: assert property (OVERTEMPERATURE_ALARM |=> !DC_INPUT_ENABLE)
        else $error("dc input on during overtemperature");
    switch_off_dc_a: assert property (POWER_SWITCH_OFF |=> !DC_INPUT_ENABLE)
        else $error("dc input on after switch off");
    switch_store_a: assert property ($rose(POWER_SWITCH_OFF) |=> NV_STORE ##1 !NV_STORE)
        else $error("store pulse missing after switch off");
    new_file_pulse_a: assert property (LOG_NEW_FILE |=> !LOG_NEW_FILE)
        else $error("new file pulse too long");
    new_file_log_a: assert property (LOG_NEW_FILE |-> ##[0:1] LOG_ACTIVE)
        else $error("new file without logging");
    record_pulse_a: assert property (LOG_RECORD |=> !LOG_RECORD)
        else $error("record pulse too long");
    record_log_a: assert property (LOG_RECORD |-> LOG_ACTIVE || $past(LOG_ACTIVE))
        else $error("record while not logging");
    backlight_wake_a: assert property (USER_ACTIVITY |-> ##[1:2] BACKLIGHT_ON)
        else $error("backlight not on after activity");
    reset_state_a: assert property ($fell(RST) |-> !DC_INPUT_ENABLE && !LOG_ACTIVE && BACKLIGHT_ON && !IRQ)
        else $error("outputs not at reset values");

    cover property ($rose(DC_INPUT_ENABLE));
    cover property ($rose(LOG_RECORD));
    cover property ($fell(BACKLIGHT_ON));
    cover property (NV_STORE);
endmodule

// [lsap_remote_model.sv]
// model: external controller wired to the analog remote interface
`timescale 1ns/1ps
module lsap_remote_model (
    input  wire logic clk,
    input  wire logic standby_req,
    input  wire logic inverted,
    input  wire logic analog_req,
    input  wire logic remote_req,
    output logic      standby_pin,
    output logic      analog_pin,
    output logic      remote_pin
);
    initial
    begin
        standby_pin = 1'h0;
        analog_pin  = 1'h0;
        remote_pin  = 1'h0;
    end
    // standby pin level is the request flipped by the chosen polarity; analog and remote pins follow their requests
    always @(posedge clk)
    begin
        standby_pin <= standby_req ^ inverted;
        analog_pin  <= analog_req;
        remote_pin  <= remote_req;
    end
endmodule

// [lsap_top.sv]
// module: DC input state control, analog status pins and register slave
//
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module lsap_top #(
    parameter int unsigned CYCLES_PER_MS = lsap_pkg::CYCLES_PER_MS
) (
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic             IRQ,
    // device state
    input  wire logic        OVERTEMPERATURE_ALARM,
    input  wire logic        POWER_FAIL_ALARM,
    input  wire logic        OVERVOLTAGE_ALARM,
    input  wire logic        OVERCURRENT_ALARM,
    input  wire logic        OVERPOWER_ALARM,
    input  wire logic        CONSTANT_VOLTAGE_REGULATION,
    input  wire logic        REMOTE_STANDBY_INPUT,
    input  wire logic        ANALOG_REMOTE_ACTIVE,
    input  wire logic        REMOTE_ACTIVE,
    input  wire logic        POWER_SWITCH_OFF,
    input  wire logic        USER_ACTIVITY,
    input  wire logic        BOOT_LOAD,
    input  wire logic        NV_RESTORE_POLICY,
    input  wire logic        NV_DC_STATE,
    output logic             DC_INPUT_ENABLE,
    output logic             STATUS_PIN6,
    output logic             STATUS_PIN14,
    output logic             STATUS_PIN15,
    output logic             REF_SELECT_10V,
    output logic             BACKLIGHT_ON,
    output logic             LOG_ACTIVE,
    output logic             LOG_NEW_FILE,
    output logic             LOG_RECORD,
    output logic             NV_STORE,
    output logic             NV_STORE_DC
);
    if (CYCLES_PER_MS < 1)
    begin : g_check
        $error("lsap_top needs at least one clock cycle per millisecond");
    end

    // ======================================================
    // register bus
    lsap_pkg::lsap_config_t    cfg;
    logic [lsap_pkg::IRQ_W-1:0] irq_status;
    logic [lsap_pkg::IRQ_W-1:0] irq_mask;
    logic [lsap_pkg::IRQ_W-1:0] irq_set;
    logic [lsap_pkg::CNT_W-1:0] alarm_count;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic        addr_phase;
    logic        wr_cfg;
    logic        wr_ctrl;
    logic        wr_istat;
    logic        wr_imask;
    logic [31:0] status_word;
    logic        dc_on;
    logic        log_on;
    logic        backlight;

    assign HREADYOUT  = 1'b1;
    assign HRESP      = 1'b0;
    assign addr_phase = HSEL & HTRANS[1] & HREADY;
    assign wr_cfg     = wr_pend & (wr_addr == lsap_pkg::ADDR_CONFIG);
    assign wr_ctrl    = wr_pend & (wr_addr == lsap_pkg::ADDR_CONTROL);
    assign wr_istat   = wr_pend & (wr_addr == lsap_pkg::ADDR_IRQ_STAT);
    assign wr_imask   = wr_pend & (wr_addr == lsap_pkg::ADDR_IRQ_MASK);
    assign status_word = {26'h0000000, STATUS_PIN15, STATUS_PIN14, STATUS_PIN6,
                          log_on, backlight, dc_on};

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            HRDATA  <= 32'h00000000;
        end
        else
        begin
            wr_pend <= addr_phase & HWRITE;
            if (addr_phase)
            begin
                wr_addr <= {HADDR[7:2], 2'b00};
            end
            if (addr_phase & ~HWRITE)
            begin
                case ({HADDR[7:2], 2'b00})
                    lsap_pkg::ADDR_CONFIG:    HRDATA <= {15'h0000, cfg};
                    lsap_pkg::ADDR_STATUS:    HRDATA <= status_word;
                    lsap_pkg::ADDR_IRQ_STAT:  HRDATA <= {25'h0000000, irq_status};
                    lsap_pkg::ADDR_IRQ_MASK:  HRDATA <= {25'h0000000, irq_mask};
                    lsap_pkg::ADDR_ALARM_CNT: HRDATA <= {16'h0000, alarm_count};
                    default:                  HRDATA <= 32'h00000000;
                endcase
            end
        end
    end

    // ======================================================
    // configuration storage
    logic sw_on;
    logic sw_off;
    logic log_toggle;
    logic factory;
    logic activity;
    lsap_pkg::lsap_config_t cfg_wr;

    assign sw_on      = wr_ctrl & HWDATA[lsap_pkg::CTRL_DC_ON];
    assign sw_off     = wr_ctrl & HWDATA[lsap_pkg::CTRL_DC_OFF];
    assign log_toggle = wr_ctrl & HWDATA[lsap_pkg::CTRL_LOG_TGL];
    assign factory    = wr_ctrl & HWDATA[lsap_pkg::CTRL_FACTORY];
    assign activity   = USER_ACTIVITY | (wr_ctrl & HWDATA[lsap_pkg::CTRL_ACTIVITY]);

    // empty selections are not offered, so they keep the old choice
    always_comb
    begin
        cfg_wr = HWDATA[lsap_pkg::CFG_W-1:0];
        if (cfg_wr.pin6_select == 2'h0)
        begin
            cfg_wr.pin6_select = cfg.pin6_select;
        end
        if (cfg_wr.pin14_select == 3'h0)
        begin
            cfg_wr.pin14_select = cfg.pin14_select;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            cfg <= lsap_pkg::CFG_RESET;
        end
        else if (factory)
        begin
            cfg <= lsap_pkg::CFG_RESET;
        end
        else if (wr_cfg)
        begin
            cfg <= cfg_wr;
        end
        else if (BOOT_LOAD)
        begin
            cfg.power_on_restore <= NV_RESTORE_POLICY;
        end
    end

    // ======================================================
    // edge detection
    lsap_pkg::lsap_alarm_t alarm;
    lsap_pkg::lsap_alarm_t alarm_prev;
    lsap_pkg::lsap_alarm_t alarm_rise;
    logic standby_act;
    logic standby_prev;
    logic remote_prev;
    logic psw_prev;
    logic power_down;
    logic psw_rise;

    assign alarm = {OVERPOWER_ALARM, OVERCURRENT_ALARM, OVERVOLTAGE_ALARM,
                    POWER_FAIL_ALARM, OVERTEMPERATURE_ALARM};
    assign alarm_rise  = alarm & ~alarm_prev;
    assign standby_act = REMOTE_STANDBY_INPUT ^ cfg.standby_inverted;
    assign psw_rise    = POWER_SWITCH_OFF & ~psw_prev;

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            alarm_prev   <= '0;
            standby_prev <= 1'b0;
            remote_prev  <= 1'b0;
            psw_prev     <= 1'b0;
        end
        else
        begin
            alarm_prev   <= alarm;
            standby_prev <= standby_act;
            remote_prev  <= REMOTE_ACTIVE;
            psw_prev     <= POWER_SWITCH_OFF;
        end
    end

    // ======================================================
    // DC input state
    logic next_dc;
    logic pl_resume;
    logic th_resume;
    logic sb_resume;
    logic sb_rise;
    logic sb_fall;

    assign sb_rise = standby_act & ~standby_prev;
    assign sb_fall = ~standby_act & standby_prev;

    always_comb
    begin
        next_dc = dc_on;
        if (sw_on)
        begin
            next_dc = 1'b1;
        end
        if (sw_off)
        begin
            next_dc = 1'b0;
        end
        if (ANALOG_REMOTE_ACTIVE & sb_fall)
        begin
            next_dc = 1'b1;
        end
        if (~ANALOG_REMOTE_ACTIVE & sb_fall & cfg.standby_on_off & sb_resume)
        begin
            next_dc = 1'b1;
        end
        if (remote_prev & ~REMOTE_ACTIVE & ~cfg.remote_keep)
        begin
            next_dc = 1'b0;
        end
        if (~POWER_FAIL_ALARM & alarm_prev.pl & pl_resume)
        begin
            next_dc = 1'b1;
        end
        if (~OVERTEMPERATURE_ALARM & alarm_prev.th & th_resume)
        begin
            next_dc = 1'b1;
        end
        if (BOOT_LOAD)
        begin
            next_dc = NV_RESTORE_POLICY & NV_DC_STATE;
        end
        // standby holds the stage off while active; its release may turn it back on
        if (standby_act)
        begin
            next_dc = 1'b0;
        end
        if (alarm.pl | alarm.th)
        begin
            next_dc = 1'b0;
        end
        if (POWER_SWITCH_OFF | power_down)
        begin
            next_dc = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            dc_on      <= 1'b0;
            pl_resume  <= 1'b0;
            th_resume  <= 1'b0;
            sb_resume  <= 1'b0;
            power_down <= 1'b0;
        end
        else
        begin
            dc_on <= next_dc;
            if (psw_rise)
            begin
                power_down <= 1'b1;
            end
            if (sw_off)
            begin
                pl_resume <= 1'b0;
                th_resume <= 1'b0;
                sb_resume <= 1'b0;
            end
            if (alarm_rise.pl)
            begin
                pl_resume <= cfg.pl_auto & dc_on;
            end
            if (alarm_rise.th)
            begin
                th_resume <= ~cfg.th_stay_off & dc_on;
            end
            if (sb_rise)
            begin
                sb_resume <= dc_on;
            end
        end
    end

    // ======================================================
    // switch-off store and alarm counting
    logic any_alarm;

    assign any_alarm = (|alarm_rise) | psw_rise;

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            NV_STORE    <= 1'b0;
            NV_STORE_DC <= 1'b0;
            alarm_count <= '0;
        end
        else
        begin
            NV_STORE <= psw_rise;
            if (psw_rise)
            begin
                NV_STORE_DC <= dc_on;
            end
            if (any_alarm & ~&alarm_count)
            begin
                alarm_count <= alarm_count + 1'b1;
            end
        end
    end

    // ======================================================
    // status pins
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            STATUS_PIN6    <= 1'b0;
            STATUS_PIN14   <= 1'b0;
            STATUS_PIN15   <= 1'b0;
            REF_SELECT_10V <= 1'b0;
        end
        else
        begin
            STATUS_PIN6    <= |(cfg.pin6_select & {alarm.pl, alarm.th});
            STATUS_PIN14   <= |(cfg.pin14_select & {alarm.ovw, alarm.ovi, alarm.ovv});
            STATUS_PIN15   <= cfg.pin15_dc_status ? dc_on
                                                  : CONSTANT_VOLTAGE_REGULATION;
            REF_SELECT_10V <= cfg.range_10v;
        end
    end

    assign DC_INPUT_ENABLE = dc_on;

    // ======================================================
    // millisecond timers: backlight and logging
    logic        ms_tick;
    logic [15:0] idle_ms;
    logic [15:0] rec_ms;
    logic        log_start;
    logic        log_stop;
    logic        rec_due;

    lsap_ms_tick #(
        .CYCLES (CYCLES_PER_MS)
    ) u_tick (
        .clk  (REF_CLK),
        .rst  (RST),
        .tick (ms_tick)
    );

    assign backlight = ~cfg.backlight_timeout
                     | (idle_ms < 16'(lsap_pkg::BACKLIGHT_MS));
    assign BACKLIGHT_ON = backlight;
    assign log_start = cfg.log_dc_coupled ? (next_dc & ~dc_on)
                                          : (log_toggle & ~log_on);
    assign log_stop  = cfg.log_dc_coupled ? (~next_dc & dc_on)
                                          : (log_toggle & log_on);
    assign rec_due   = ms_tick
                     & (rec_ms == lsap_pkg::LOG_INTERVAL_MS[cfg.log_interval] - 16'h0001);
    assign LOG_ACTIVE = log_on;

    always_ff @(posedge REF_CLK)
    begin
        if (RST | activity)
        begin
            idle_ms <= 16'h0000;
        end
        else if (ms_tick & (idle_ms < 16'(lsap_pkg::BACKLIGHT_MS)))
        begin
            idle_ms <= idle_ms + 16'h0001;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            log_on       <= 1'b0;
            rec_ms       <= 16'h0000;
            LOG_NEW_FILE <= 1'b0;
            LOG_RECORD   <= 1'b0;
        end
        else
        begin
            LOG_NEW_FILE <= log_start;
            LOG_RECORD   <= log_on & rec_due;
            if (log_start)
            begin
                log_on <= 1'b1;
                rec_ms <= 16'h0000;
            end
            else if (log_stop)
            begin
                log_on <= 1'b0;
            end
            else if (log_on & ms_tick)
            begin
                rec_ms <= rec_due ? 16'h0000 : rec_ms + 16'h0001;
            end
        end
    end

    // ======================================================
    // interrupts
    assign irq_set = {LOG_RECORD, next_dc ^ dc_on, alarm_rise.ovw, alarm_rise.ovi,
                      alarm_rise.ovv, alarm_rise.pl | psw_rise, alarm_rise.th};
    assign IRQ = |(irq_status & irq_mask);

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            irq_status <= '0;
            irq_mask   <= '0;
        end
        else
        begin
            // a new event wins over a clear in the same cycle
            irq_status <= (irq_status & ~(wr_istat ? HWDATA[lsap_pkg::IRQ_W-1:0] : '0))
                        | irq_set;
            if (wr_imask)
            begin
                irq_mask <= HWDATA[lsap_pkg::IRQ_W-1:0];
            end
        end
    end
endmodule

// [tb.sv]
// testbench: bus-driven scenarios for the load input state block
`timescale 1ns/1ps
module tb;
    localparam int unsigned CPM = 1;
    localparam logic [7:0] A_CF = lsap_pkg::ADDR_CONFIG;
    localparam logic [7:0] A_CT = lsap_pkg::ADDR_CONTROL;
    localparam logic [7:0] A_IS = lsap_pkg::ADDR_IRQ_STAT;
    localparam logic [7:0] A_IM = lsap_pkg::ADDR_IRQ_MASK;
    localparam logic [7:0] A_AC = lsap_pkg::ADDR_ALARM_CNT;
    logic REF_CLK = 1'h0, RST = 1'h1, HSEL = 1'h0, HWRITE = 1'h0, HREADY;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rdat;
    logic [1:0] HTRANS = 2'h0;
    logic [2:0] HSIZE = 3'h2;
    lsap_pkg::lsap_alarm_t alm = '0;
    logic CONSTANT_VOLTAGE_REGULATION = 1'h0, POWER_SWITCH_OFF = 1'h0, USER_ACTIVITY = 1'h0;
    logic BOOT_LOAD = 1'h0, NV_RESTORE_POLICY = 1'h0, NV_DC_STATE = 1'h0;
    logic sb_req = 1'h0, sb_inv = 1'h0, rm_req = 1'h0, an_req = 1'h0;
    logic REMOTE_STANDBY_INPUT, ANALOG_REMOTE_ACTIVE, REMOTE_ACTIVE, HREADYOUT, HRESP, IRQ;
    logic DC_INPUT_ENABLE, STATUS_PIN6, STATUS_PIN14, STATUS_PIN15, REF_SELECT_10V;
    logic BACKLIGHT_ON, LOG_ACTIVE, LOG_NEW_FILE, LOG_RECORD, NV_STORE, NV_STORE_DC;
    int errors = 0, tests_run = 0, nfiles = 0, n = 0, c0 = 0;

    always #20 REF_CLK = ~REF_CLK;
    assign HREADY = HREADYOUT;
    always @(posedge REF_CLK) if (LOG_NEW_FILE === 1'h1) nfiles++;

    lsap_remote_model i_lsap_remote_model (.clk(REF_CLK), .standby_req(sb_req),
        .inverted(sb_inv), .analog_req(an_req), .remote_req(rm_req),
        .standby_pin(REMOTE_STANDBY_INPUT), .analog_pin(ANALOG_REMOTE_ACTIVE),
        .remote_pin(REMOTE_ACTIVE));
    lsap_top #(.CYCLES_PER_MS(CPM)) i_lsap_top (.REF_CLK, .RST, .HSEL, .HADDR, .HTRANS,
        .HWRITE, .HSIZE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .IRQ,
        .OVERTEMPERATURE_ALARM(alm.th), .POWER_FAIL_ALARM(alm.pl),
        .OVERVOLTAGE_ALARM(alm.ovv), .OVERCURRENT_ALARM(alm.ovi), .OVERPOWER_ALARM(alm.ovw),
        .CONSTANT_VOLTAGE_REGULATION, .REMOTE_STANDBY_INPUT, .ANALOG_REMOTE_ACTIVE,
        .REMOTE_ACTIVE, .POWER_SWITCH_OFF, .USER_ACTIVITY, .BOOT_LOAD, .NV_RESTORE_POLICY,
        .NV_DC_STATE, .DC_INPUT_ENABLE, .STATUS_PIN6, .STATUS_PIN14, .STATUS_PIN15,
        .REF_SELECT_10V, .BACKLIGHT_ON, .LOG_ACTIVE, .LOG_NEW_FILE, .LOG_RECORD,
        .NV_STORE, .NV_STORE_DC);

    task close_out;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
        tests_run++;
        if (s !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task cb(input logic s, input logic e, input string nm);
        chk({31'h0, s}, {31'h0, e}, nm);
    endtask
    task tk(input int k);
        repeat (k) @(posedge REF_CLK);
    endtask
    // bounded wait until a signal shows a level; k counts edges
    task automatic wt(ref logic s, input logic v, input int lim, output int k);
        k = 0;
        do
        begin
            @(posedge REF_CLK);
            k++;
        end
        while (s !== v && k < lim);
        if (k >= lim)
        begin
            errors++;
            close_out();
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'h1;
        HTRANS <= 2'h2;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        wt(HREADY, 1'h1, 64, n);
        HSEL <= 1'h0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        wt(HREADY, 1'h1, 64, n);
        rdat = HRDATA;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'h0, a, 32'h0);
        chk(rdat, e, nm);
    endtask
    task dc(input logic [31:0] b);
        wr(A_CT, b);
        tk(3);
    endtask

    // ======================================================
    // scenarios
    initial
    begin
        tk(4);
        RST <= 1'h0;
        tk(1);
        rd(A_CF, 32'h38, "config");
        rd(A_IM, 32'h0, "mask");
        rd(lsap_pkg::ADDR_STATUS, 32'h2, "status");
        rd(A_AC, 32'h0, "count");
        cb(HRESP, 1'h0, "resp");
        wr(8'h18, 32'hFFFFFFFF);
        rd(8'h18, 32'h0, "unmapped");
        for (int i = 0; i < 2; i++)
        begin
            wr(A_CF, 32'h38 | i);
            tk(2);
            cb(REF_SELECT_10V, i[0], "range");
        end
        for (int s = 1; s < 8; s++)
        begin
            wr(A_CF, {24'h0, s[2:0], 5'h18});
            for (int k = 0; k < 3; k++)
            begin
                alm[2 + k] <= 1'h1;
                tk(3);
                cb(STATUS_PIN14, s[k], "pin14");
                alm <= '0;
                tk(2);
            end
        end
        for (int s = 1; s < 4; s++)
        begin
            wr(A_CF, {24'h0, 3'h1, s[1:0], 3'h0});
            for (int k = 0; k < 2; k++)
            begin
                alm[k] <= 1'h1;
                tk(3);
                cb(STATUS_PIN6, s[k], "pin6");
                alm <= '0;
                tk(3);
            end
        end
        wr(A_CF, 32'h00010138);
        CONSTANT_VOLTAGE_REGULATION <= 1'h1;
        tk(3);
        cb(STATUS_PIN15, 1'h0, "pin15 dc");
        for (int i = 0; i < 2; i++)
        begin
            dc(32'h1);
            cb(STATUS_PIN15, 1'h1, "pin15 dc");
            cb(LOG_ACTIVE, 1'h1, "log on");
            dc(32'h2);
            cb(LOG_ACTIVE, 1'h0, "log off");
        end
        chk(nfiles, 32'h2, "new files");
        wr(A_CF, 32'h38);
        tk(2);
        cb(STATUS_PIN15, 1'h1, "pin15 rm");
        dc(32'h1);
        cb(LOG_ACTIVE, 1'h0, "manual log");
        dc(32'h4);
        cb(LOG_ACTIVE, 1'h1, "manual toggle");
        dc(32'h2);
        cb(LOG_ACTIVE, 1'h1, "manual keeps");
        dc(32'h4);
        cb(LOG_ACTIVE, 1'h0, "manual toggle");
        for (int i = 0; i < 5; i++)
        begin
            wr(A_CF, 32'h38 | (i << 1));
            sb_inv <= i[0];
            an_req <= i[2];
            tk(3);
            dc(32'h1);
            sb_req <= 1'h1;
            tk(4);
            cb(DC_INPUT_ENABLE, 1'h0, "standby off");
            sb_req <= 1'h0;
            tk(4);
            cb(DC_INPUT_ENABLE, i[1] | i[2], "standby release");
            dc(32'h2);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(A_CF, 32'h38 | (i[1] << (i[0] ? 10 : 12)));
            dc(32'h1);
            alm[i[0]] <= 1'h1;
            tk(3);
            cb(DC_INPUT_ENABLE, 1'h0, "alarm off");
            alm <= '0;
            tk(4);
            cb(DC_INPUT_ENABLE, i[0] ~^ i[1], "after alarm");
            dc(32'h2);
        end
        for (int i = 0; i < 2; i++)
        begin
            wr(A_CF, 32'h38 | (i << 11));
            rm_req <= 1'h1;
            tk(3);
            dc(32'h1);
            rm_req <= 1'h0;
            tk(4);
            cb(DC_INPUT_ENABLE, i[0], "leave remote");
            dc(32'h2);
        end
        for (int i = 0; i < 2; i++)
        begin
            NV_RESTORE_POLICY <= i[0];
            NV_DC_STATE <= 1'h1;
            BOOT_LOAD <= 1'h1;
            tk(1);
            BOOT_LOAD <= 1'h0;
            tk(3);
            cb(DC_INPUT_ENABLE, i[0], "boot");
            dc(32'h2);
        end
        wr(A_CT, 32'h8);
        rd(A_CF, 32'h38, "factory");
        bus(1'h0, A_AC, 32'h0);
        c0 = rdat;
        alm <= 5'h0C;
        tk(3);
        alm <= 5'h02;
        tk(3);
        alm <= '0;
        tk(4);
        rd(A_AC, c0 + 2, "count");
        wr(A_IS, 32'h7F);
        wr(A_IM, 32'h4);
        alm.ovi <= 1'h1;
        tk(3);
        alm <= '0;
        rd(A_IS, 32'h8, "irq status");
        cb(IRQ, 1'h0, "irq masked");
        alm.ovv <= 1'h1;
        tk(3);
        alm <= '0;
        cb(IRQ, 1'h1, "irq");
        wr(A_IS, 32'h4);
        tk(2);
        cb(IRQ, 1'h0, "irq clear");
        for (int i = 0; i < 4; i++)
        begin
            wr(A_CF, 32'h00010038 | (i << 14));
            dc(32'h1);
            wt(LOG_RECORD, 1'h1, 6000, n);
            wt(LOG_RECORD, 1'h1, 6000, n);
            chk(n, lsap_pkg::LOG_INTERVAL_MS[i] * CPM, "record gap");
            dc(32'h2);
        end
        wr(A_CF, 32'h2038);
        USER_ACTIVITY <= 1'h1;
        tk(1);
        USER_ACTIVITY <= 1'h0;
        wt(BACKLIGHT_ON, 1'h0, 61000, n);
        cb(n >= 59998 * CPM && n <= 60003 * CPM, 1'h1, "backlight time");
        wr(A_CT, 32'h10);
        tk(1);
        cb(BACKLIGHT_ON, 1'h1, "backlight wake");
        dc(32'h1);
        POWER_SWITCH_OFF <= 1'h1;
        tk(3);
        cb(DC_INPUT_ENABLE, 1'h0, "switch off");
        cb(NV_STORE_DC, 1'h1, "stored dc");
        RST <= 1'h1;
        POWER_SWITCH_OFF <= 1'h0;
        tk(4);
        RST <= 1'h0;
        tk(2);
        dc(32'h1);
        cb(DC_INPUT_ENABLE, 1'h1, "after reset");
        close_out();
    end
endmodule

bind lsap_top lsap_props i_lsap_props (.REF_CLK, .RST,
    .IRQ, .OVERTEMPERATURE_ALARM, .POWER_FAIL_ALARM, .POWER_SWITCH_OFF, .USER_ACTIVITY,
    .DC_INPUT_ENABLE, .BACKLIGHT_ON, .LOG_ACTIVE, .LOG_NEW_FILE, .LOG_RECORD, .NV_STORE);
